// file: verilog/fuse_defines.svh
// fuse block constants: offsets, fields, reset values
// assumes: APB byte address = 4 * register index
`ifndef FUSE_DEFINES_SVH
`define FUSE_DEFINES_SVH

`define OPT4_IDX      24'h300006
`define PROT5_IDX     24'h300008
`define STATUS_IDX    24'h300010
`define ERASE_IDX     24'h300012
`define OPT4_ADDR     ({6'h00, `OPT4_IDX, 2'b00})
`define PROT5_ADDR    ({6'h00, `PROT5_IDX, 2'b00})
`define STATUS_ADDR   ({6'h00, `STATUS_IDX, 2'b00})
`define ERASE_ADDR    ({6'h00, `ERASE_IDX, 2'b00})

`define STACK_RST_BIT 0
`define LVP_BIT       2
`define DBG_BIT       7
`define OPT4_MASK     8'h85
`define PROT5_MASK    8'h0f
`define OPT4_RESET    8'h85
`define PROT5_RESET   8'h0f
`define ERASE_BIT     0

`define BLOCK_MSB     14
`define BLOCK_LSB     13
`define PROT_LIMIT    21'h008000

`endif

// file: verilog/fuse_pkg.sv
// fuse block types
// assumes: fuse_defines.svh for all numbers
package fuse_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic [7:0] opt4;
        logic [7:0] prot5;
        apb_rsp_s   rsp;
        logic       stack_rst;
        logic       lvp_grant;
        logic       dbg_en;
        logic       prot_hit;
    } fuse_state_s;

endpackage : fuse_pkg

// file: verilog/level_sync.sv
// two-flop synchroniser for pin levels
// assumes: input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    always_comb begin
        state_next.first  = async_in;
        // first stage feeds only the second
        state_next.second = state_reg.first;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;
endmodule : level_sync
`default_nettype wire

// file: verilog/config_fuse_protection.sv
// configuration option and code-protect fuse bytes behind APB
// assumes: stack_fault and query_addr come from core logic on clk;
// lvp_entry_pin is an external pin
// limitation: fuses are flops here, so every reset unprograms them
`timescale 1ns/1ps
`default_nettype none
`include "fuse_defines.svh"
module config_fuse_protection #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire fuse_pkg::apb_req_s apb_req,
    output var  fuse_pkg::apb_rsp_s apb_rsp,
    input  wire logic              stack_fault,
    input  wire logic              lvp_entry_pin,
    input  wire logic [20:0]       query_addr,
    output var  logic              stack_fault_reset,
    output var  logic              low_voltage_programming_enable,
    output var  logic              debugger_enable,
    output var  logic              block_protect_hit
);
    import fuse_pkg::*;

    fuse_state_s state_reg;
    fuse_state_s state_next;
    logic        lvp_req_sync;
    logic        access;
    logic        commit;
    logic        wr_opt4;
    logic        wr_prot5;
    logic        erase_wr;
    logic        mapped;
    logic [1:0]  block_sel;

    ////////////////////////////////////////////////////////////////////
    // pin crossing

    level_sync #(
        .W (1)
    ) u_lvp_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (lvp_entry_pin),
        .sync_out (lvp_req_sync)
    );

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next = state_reg;
        access     = apb_req.psel && apb_req.penable;
        // one wait state so every answer comes from a flop
        commit     = access && state_reg.rsp.pready;
        mapped     = (apb_req.paddr == `OPT4_ADDR)
                  || (apb_req.paddr == `PROT5_ADDR)
                  || (apb_req.paddr == `STATUS_ADDR)
                  || (apb_req.paddr == `ERASE_ADDR);
        wr_opt4    = commit && apb_req.pwrite
                  && (apb_req.paddr == `OPT4_ADDR);
        wr_prot5   = commit && apb_req.pwrite
                  && (apb_req.paddr == `PROT5_ADDR);
        erase_wr   = commit && apb_req.pwrite
                  && (apb_req.paddr == `ERASE_ADDR)
                  && apb_req.pwdata[`ERASE_BIT];
        block_sel  = query_addr[`BLOCK_MSB:`BLOCK_LSB];

        state_next.rsp.pready  = access && !state_reg.rsp.pready;
        state_next.rsp.pslverr = access && !state_reg.rsp.pready
                              && !mapped;
        state_next.rsp.prdata  = '0;
        if (access && !state_reg.rsp.pready && !apb_req.pwrite) begin
            unique case (apb_req.paddr)
                `OPT4_ADDR:   state_next.rsp.prdata =
                                  {24'h000000, state_reg.opt4};
                `PROT5_ADDR:  state_next.rsp.prdata =
                                  {24'h000000, state_reg.prot5};
                `STATUS_ADDR: state_next.rsp.prdata =
                                  {28'h0000000, state_reg.prot_hit,
                                   state_reg.dbg_en,
                                   state_reg.lvp_grant,
                                   state_reg.stack_rst};
                default:      state_next.rsp.prdata = '0;
            endcase
        end

        if (erase_wr) begin
            // full erase returns every fuse to unprogrammed
            state_next.opt4  = `OPT4_RESET;
            state_next.prot5 = `PROT5_RESET;
        end else begin
            if (wr_opt4) begin
                state_next.opt4 = apb_req.pwdata[7:0] & `OPT4_MASK;
            end
            if (wr_prot5) begin
                // programming can only clear a flag
                state_next.prot5 = state_reg.prot5
                                 & apb_req.pwdata[7:0]
                                 & `PROT5_MASK;
                if (SMALL_VARIANT) begin
                    // absent flags held set even if misprogrammed
                    state_next.prot5[3:2] = 2'b11;
                end
            end
        end

        // stack and protect outputs follow their inputs one cycle later, lvp three cycles after the pin; dbg_en changes on the same edge as opt4
        state_next.stack_rst = stack_fault
            && state_reg.opt4[`STACK_RST_BIT];
        state_next.lvp_grant = lvp_req_sync
            && state_reg.opt4[`LVP_BIT];
        state_next.dbg_en    = !state_next.opt4[`DBG_BIT];
        // blocks 0..3 are 8k words each below the limit
        state_next.prot_hit  = (query_addr < `PROT_LIMIT)
            && !state_reg.prot5[block_sel];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // answer and core outputs quiet, fuses unprogrammed
            state_reg           <= '0;
            state_reg.opt4      <= `OPT4_RESET;
            state_reg.prot5     <= `PROT5_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign apb_rsp                        = state_reg.rsp;
    assign stack_fault_reset              = state_reg.stack_rst;
    assign low_voltage_programming_enable = state_reg.lvp_grant;
    assign debugger_enable                = state_reg.dbg_en;
    assign block_protect_hit              = state_reg.prot_hit;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_stack_reset_on: assert property (
        stack_fault && state_reg.opt4[0] |=> stack_fault_reset)
        else $error("stack fault with reset enabled gave no reset");
    chk_stack_reset_off: assert property (
        !state_reg.opt4[0] |=> !stack_fault_reset)
        else $error("stack fault reset while disabled");
    chk_lvp_gate: assert property (
        low_voltage_programming_enable |-> $past(state_reg.opt4[2]))
        else $error("low-voltage entry granted while disabled");

    // core-side outputs
    chk_stack_idle: assert property (
        !stack_fault |=> !stack_fault_reset)
        else $error("stack fault reset without a fault");
    chk_lvp_grant_on: assert property (
        lvp_req_sync && state_reg.opt4[`LVP_BIT]
        |=> low_voltage_programming_enable)
        else $error("low-voltage entry refused while enabled");
    chk_lvp_no_pin: assert property (
        !lvp_req_sync |=> !low_voltage_programming_enable)
        else $error("low-voltage entry granted without a request");
    chk_block3_prot: assert property (
        query_addr >= 21'h006000 && query_addr <= 21'h007fff
        && !state_reg.prot5[3] |=> block_protect_hit)
        else $error("block 3 not protected");
    chk_block2_prot: assert property (
        query_addr >= 21'h004000 && query_addr <= 21'h005fff
        |=> block_protect_hit == !$past(state_reg.prot5[2]))
        else $error("block 2 protection wrong");
    chk_block1_prot: assert property (
        query_addr >= 21'h002000 && query_addr <= 21'h003fff
        |=> block_protect_hit == !$past(state_reg.prot5[1]))
        else $error("block 1 protection wrong");
    chk_block0_prot: assert property (
        query_addr <= 21'h001fff
        |=> block_protect_hit == !$past(state_reg.prot5[0]))
        else $error("block 0 protection wrong");

    // protection map, fuse bytes and the apb wait state
    chk_block3_open: assert property (
        query_addr >= 21'h006000 && query_addr <= 21'h007fff
        && state_reg.prot5[3] |=> !block_protect_hit)
        else $error("block 3 protected while its flag is set");
    chk_above_blocks: assert property (
        query_addr >= `PROT_LIMIT |=> !block_protect_hit)
        else $error("address above the blocks reported protected");
    chk_erase_restore: assert property (
        erase_wr |=> state_reg.opt4 == `OPT4_RESET
                     && state_reg.prot5 == `PROT5_RESET)
        else $error("erase left a fuse byte programmed");
    chk_opt4_write: assert property (
        wr_opt4 |=> state_reg.opt4 == ($past(apb_req.pwdata[7:0]) & `OPT4_MASK))
        else $error("option byte write not masked");
    chk_unimpl_zero: assert property (
        (state_reg.opt4 & 8'h7a) == 8'h00
        && state_reg.prot5[7:4] == 4'h0)
        else $error("unimplemented fuse bit set");
    chk_flag_no_set: assert property (
        !erase_wr |=> (state_reg.prot5 & ~$past(state_reg.prot5))
                      == 8'h00)
        else $error("protect flag set without erase");
    chk_dbg_polarity: assert property (
        debugger_enable != state_reg.opt4[7])
        else $error("debugger enable polarity wrong");
    chk_apb_wait: assert property (
        apb_req.psel && apb_req.penable && !apb_rsp.pready
        |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("apb answer not after one wait state");

    // bus answer
    chk_slverr_unmapped: assert property (
        access && !apb_rsp.pready && !mapped |=> apb_rsp.pslverr)
        else $error("unmapped address answered without error");
    chk_prdata_idle: assert property (
        !apb_rsp.pready |-> apb_rsp.prdata == 32'h00000000)
        else $error("read data outside the answer cycle");
    chk_pready_pulse: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held longer than one cycle");

endmodule : config_fuse_protection
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the configuration fuse block
// assumes: APB slave answers with pready; fuse byte addresses from defines
`timescale 1ns/1ps
`default_nettype none
`include "fuse_defines.svh"
module testbench;
    import fuse_pkg::*;
    logic           clk;
    logic           rst;
    apb_req_s       req;
    apb_rsp_s       rsp;
    logic           stack_fault;
    logic           entry_pin;
    logic [20:0]    query_addr;
    logic           sf_reset;
    logic           lv_enable;
    logic           dbg_enable;
    logic           prot_hit;
    logic [33:0]    notes[$];
    logic [33:0]    e;
    logic [7:0]     opts[4];
    logic [7:0]     opt;
    logic [3:0]     prot;
    logic [31:0]    w;
    int             fail_count;
    int             total_checks;
    int             seed;

    config_fuse_protection u_config_fuse_protection (
        .clk                            (clk),
        .rst                            (rst),
        .apb_req                        (req),
        .apb_rsp                        (rsp),
        .stack_fault                    (stack_fault),
        .lvp_entry_pin                  (entry_pin),
        .query_addr                     (query_addr),
        .stack_fault_reset              (sf_reset),
        .low_voltage_programming_enable (lv_enable),
        .debugger_enable                (dbg_enable),
        .block_protect_hit              (prot_hit)
    );

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // note goes in before the request so the monitor never runs dry
    task automatic apb(input logic wr, input logic [31:0] a, d, ex,
                       input logic er);
        int n;
        notes.push_back({~wr, er, ex});
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            end_of_test();
        end
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (rsp.pready === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                e = notes.pop_front();
                check({31'h0, rsp.pslverr}, {31'h0, e[32]});
                if (e[33]) check(rsp.prdata, e[31:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0; rst = 1; req = '0; stack_fault = 0; entry_pin = 0;
        query_addr = '0; fail_count = 0; total_checks = 0; seed = 21468;
        opts = '{8'h00, 8'h85, 8'h04, 8'h81};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, `OPT4_ADDR, 0, 32'h85, 0);
        apb(0, `PROT5_ADDR, 0, 32'h0f, 0);
        apb(1, `OPT4_ADDR, 32'hffffffff, 0, 0);
        apb(0, `OPT4_ADDR, 0, 32'h85, 0);
        apb(0, 32'h00000004, 0, 0, 1);
        foreach (opts[i]) begin
            opt = opts[i];
            apb(1, `OPT4_ADDR, {24'h0, opt}, 0, 0);
            apb(0, `OPT4_ADDR, 0, {24'h0, opt}, 0);
            stack_fault <= 1'b1;
            @(posedge clk);
            stack_fault <= 1'b0;
            @(posedge clk);
            check({31'h0, sf_reset}, {31'h0, opt[0]});
            entry_pin <= 1'b1;
            // pin passes a two-flop synchroniser first
            repeat (4) @(posedge clk);
            check({31'h0, lv_enable}, {31'h0, opt[2]});
            check({31'h0, dbg_enable}, {31'h0, ~opt[7]});
            apb(0, `STATUS_ADDR, 0,
                {28'h0, 1'b0, ~opt[7], opt[2], 1'b0}, 0);
            entry_pin <= 1'b0;
        end
        prot = 4'hf;
        for (int k = 0; k < 5; k++) begin
            w = $random(seed);
            // first write leaves blocks 3 and 2 open, as small parts need
            if (k == 0) w[3:2] = 2'b11;
            if (k == 4) begin
                apb(1, `ERASE_ADDR, 32'h1, 0, 0);
                prot = 4'hf;
            end else begin
                apb(1, `PROT5_ADDR, w, 0, 0);
                prot = prot & w[3:0];
            end
            apb(0, `PROT5_ADDR, 0, {28'h0, prot}, 0);
            for (int j = 0; j < 10; j++) begin
                w = $random(seed);
                query_addr <= (j == 0) ? 21'h007fff :
                              (j == 1) ? 21'h008000 : {5'h0, w[15:0]};
                @(posedge clk);
                @(posedge clk);
                check({31'h0, prot_hit}, {31'h0, query_addr < 21'h008000 &&
                      !prot[query_addr[14:13]]});
            end
        end
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
